/* tms_serial_slave.v */
// two-wire slave front end and register set of the temperature monitor
`timescale 1ns/1ps
`include "tms_map.vh"
module tms_serial_slave #(
  parameter [22:0] TIMEOUT_CYC = `TMS_TIMEOUT_CYC,
  parameter [7:0]  MAKER_ID    = 8'hA5, // arbitrary value
  parameter [7:0]  PART_ID     = 8'h3C  // arbitrary value
) (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_o,
  output reg        sda_oe_o,
  input  wire       address_select_high_i,
  output wire       address_select_high_pull_up_o,
  output wire       address_select_high_pull_dn_o,
  input  wire       address_select_low_i,
  output wire       address_select_low_pull_up_o,
  output wire       address_select_low_pull_dn_o,
  input  wire       alert_pin_function_select_i,
  output reg  [7:0] limit_pin_hyst_o,
  output reg  [7:0] shared_alert_pin_hyst_o,
  output reg  [2:0] limit_pin_need_o,
  output reg  [2:0] shared_alert_pin_need_o,
  output reg  [6:0] slave_addr_o,
  output reg        addr_valid_o,
  output reg        hs_mode_o
);

  // ************************************************************
  // states
  // ************************************************************
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_AACK = 7'h04;
  localparam [6:0] S_WR   = 7'h08;
  localparam [6:0] S_WACK = 7'h10;
  localparam [6:0] S_RD   = 7'h20;
  localparam [6:0] S_RACK = 7'h40;

  localparam integer LEN_FAST_N = `TMS_SPIKE_FAST_CYC;
  localparam integer LEN_HS_N   = `TMS_SPIKE_HS_CYC;
  localparam [3:0]   LEN_FAST   = LEN_FAST_N[3:0];
  localparam [3:0]   LEN_HS     = LEN_HS_N[3:0];

  // ************************************************************
  // functions
  // ************************************************************
  function [2:0] need_count;
    input [2:0] code;
    begin
      need_count = {2'h0, code[0]} + {2'h0, code[1]} + {2'h0, code[2]} + 3'h1;
    end
  endfunction

  function [6:0] map_addr;
    input [1:0] lvl_low;
    input [1:0] lvl_high;
    begin
      case ({lvl_low, lvl_high})
        4'h0:    map_addr = 7'h4C;
        4'h1:    map_addr = 7'h4D;
        4'h4:    map_addr = 7'h4E;
        4'h5:    map_addr = 7'h4F;
        4'h2:    map_addr = 7'h48;
        4'h8:    map_addr = 7'h49;
        4'h6:    map_addr = 7'h4A;
        4'h9:    map_addr = 7'h4B;
        4'hA:    map_addr = 7'h37;
        default: map_addr = 7'h4C;
      endcase
    end
  endfunction

  // ************************************************************
  // declarations
  // ************************************************************
  wire       scl_f;
  wire       sda_f;
  wire [1:0] lvl_high;
  wire [1:0] lvl_low;
  wire       done_high;
  wire       done_low;
  reg  [6:0] state_q;
  reg        scl_p_q;
  reg        sda_p_q;
  reg  [2:0] cnt_q;
  reg        full_q;
  reg  [7:0] sh_q;
  reg  [7:0] tx_q;
  reg        rw_q;
  reg        gc_q;
  reg        first_q;
  reg        nack_q;
  reg        frame_q;
  reg  [7:0] ptr_q;
  reg  [7:0] hyst_q;
  reg  [7:0] cfault_q;
  reg  [22:0] to_q;
  reg  [7:0] rd_data;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_ev;
  wire       stop_ev;
  wire       timeout;
  wire [7:0] rx_byte;

  // ************************************************************
  // input conditioning and address straps
  // ************************************************************
  tms_spike_filter u_scl_filt (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .line_i  (scl_i),
    .len_i   (hs_mode_o ? LEN_HS : LEN_FAST),
    .line_o  (scl_f)
  );

  tms_spike_filter u_sda_filt (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .line_i  (sda_i),
    .len_i   (hs_mode_o ? LEN_HS : LEN_FAST),
    .line_o  (sda_f)
  );

  tms_strap_sense u_strap_high (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (address_select_high_i),
    .pull_up_o (address_select_high_pull_up_o),
    .pull_dn_o (address_select_high_pull_dn_o),
    .level_o   (lvl_high),
    .done_o    (done_high)
  );

  tms_strap_sense u_strap_low (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (address_select_low_i),
    .pull_up_o (address_select_low_pull_up_o),
    .pull_dn_o (address_select_low_pull_dn_o),
    .level_o   (lvl_low),
    .done_o    (done_low)
  );

  // ************************************************************
  // bus events
  // ************************************************************
  assign sda_o    = 1'b0;
  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;
  assign start_ev = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop_ev  = scl_f & scl_p_q & ~sda_p_q & sda_f;
  assign timeout  = frame_q & (to_q >= TIMEOUT_CYC);
  assign rx_byte  = sh_q;

  // ************************************************************
  // read selection
  // ************************************************************
  always @* begin
    case (ptr_q)
      `TMS_PTR_HYST:   rd_data = hyst_q;
      `TMS_PTR_CFAULT: rd_data = cfault_q & `TMS_CFAULT_MASK;
      `TMS_PTR_PART:   rd_data = PART_ID;
      `TMS_PTR_MAKER:  rd_data = MAKER_ID;
      default:         rd_data = 8'h00;
    endcase
  end

  // ************************************************************
  // address latch and outputs to the alarm logic
  // ************************************************************
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      slave_addr_o            <= 7'h00;
      addr_valid_o            <= 1'b0;
      limit_pin_hyst_o        <= `TMS_HYST_RST;
      shared_alert_pin_hyst_o <= 8'h00;
      limit_pin_need_o        <= 3'h1;
      shared_alert_pin_need_o <= 3'h1;
    end else begin
      if (done_high && done_low && !addr_valid_o) begin
        slave_addr_o <= map_addr(lvl_low, lvl_high);
        addr_valid_o <= 1'b1;
      end
      limit_pin_hyst_o        <= hyst_q;
      shared_alert_pin_hyst_o <= alert_pin_function_select_i ? hyst_q : 8'h00;
      limit_pin_need_o        <= need_count(cfault_q[`TMS_LIM_CNT_MSB:`TMS_LIM_CNT_LSB]);
      shared_alert_pin_need_o <= need_count(cfault_q[`TMS_ALT_CNT_MSB:`TMS_ALT_CNT_LSB]);
    end
  end

  // ************************************************************
  // stuck bus timer
  // ************************************************************
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      to_q    <= 23'h000000;
      frame_q <= 1'b0;
    end else begin
      if (start_ev) begin
        frame_q <= 1'b1;
      end else if (stop_ev || timeout) begin
        frame_q <= 1'b0;
      end
      if (!frame_q || start_ev || (scl_f && sda_f)) begin
        to_q <= 23'h000000;
      end else if (!timeout) begin
        to_q <= to_q + 23'h000001;
      end
    end
  end

  // ************************************************************
  // protocol engine and registers
  // ************************************************************
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q   <= S_IDLE;
      scl_p_q   <= 1'b1;
      sda_p_q   <= 1'b1;
      cnt_q     <= 3'h0;
      full_q    <= 1'b0;
      sh_q      <= 8'h00;
      tx_q      <= 8'h00;
      rw_q      <= 1'b0;
      gc_q      <= 1'b0;
      first_q   <= 1'b0;
      nack_q    <= 1'b0;
      ptr_q     <= 8'h00;
      hyst_q    <= `TMS_HYST_RST;
      cfault_q  <= `TMS_CFAULT_RST;
      sda_oe_o  <= 1'b0;
      hs_mode_o <= 1'b0;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
      if (timeout) begin
        state_q   <= S_IDLE;
        sda_oe_o  <= 1'b0;
        hs_mode_o <= 1'b0;
      end else if (start_ev) begin
        state_q  <= S_ADDR;
        cnt_q    <= 3'h0;
        full_q   <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (stop_ev) begin
        state_q   <= S_IDLE;
        sda_oe_o  <= 1'b0;
        hs_mode_o <= 1'b0;
      end else begin
        if (scl_rise && (state_q == S_ADDR || state_q == S_WR)) begin
          sh_q  <= {sh_q[6:0], sda_f};
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'h7) begin
            full_q <= 1'b1;
          end
        end
        case (state_q)
          S_IDLE: begin
            sda_oe_o <= 1'b0;
          end
          S_ADDR: begin
            if (scl_fall && full_q) begin
              full_q <= 1'b0;
              cnt_q  <= 3'h0;
              if (addr_valid_o && rx_byte[7:1] == slave_addr_o) begin
                rw_q     <= rx_byte[0];
                gc_q     <= 1'b0;
                sda_oe_o <= 1'b1;
                state_q  <= S_AACK;
              end else if (rx_byte == `TMS_GC_ADDR) begin
                rw_q     <= 1'b0;
                gc_q     <= 1'b1;
                sda_oe_o <= 1'b1;
                state_q  <= S_AACK;
              end else if (rx_byte[7:3] == `TMS_HS_CODE) begin
                hs_mode_o <= 1'b1;
                state_q   <= S_IDLE;
              end else begin
                state_q <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              cnt_q <= 3'h0;
              if (rw_q) begin
                tx_q     <= rd_data;
                sda_oe_o <= ~rd_data[7];
                state_q  <= S_RD;
              end else begin
                sda_oe_o <= 1'b0;
                first_q  <= 1'b1;
                state_q  <= S_WR;
              end
            end
          end
          S_WR: begin
            if (scl_fall && full_q) begin
              full_q  <= 1'b0;
              cnt_q   <= 3'h0;
              first_q <= 1'b0;
              if (gc_q) begin
                if (rx_byte == `TMS_GC_RESET) begin
                  hyst_q   <= `TMS_HYST_RST;
                  cfault_q <= `TMS_CFAULT_RST;
                  sda_oe_o <= 1'b1;
                  state_q  <= S_WACK;
                end else begin
                  state_q <= S_IDLE;
                end
              end else begin
                sda_oe_o <= 1'b1;
                state_q  <= S_WACK;
                if (first_q) begin
                  ptr_q <= rx_byte;
                end else begin
                  case (ptr_q)
                    `TMS_PTR_HYST:   hyst_q   <= rx_byte;
                    `TMS_PTR_CFAULT: cfault_q <= rx_byte & `TMS_CFAULT_MASK;
                    `TMS_PTR_SWRST: begin
                      hyst_q   <= `TMS_HYST_RST;
                      cfault_q <= `TMS_CFAULT_RST;
                    end
                    default: ;
                  endcase
                end
              end
            end
          end
          S_WACK: begin
            if (scl_fall) begin
              sda_oe_o <= 1'b0;
              state_q  <= S_WR;
            end
          end
          S_RD: begin
            if (scl_fall) begin
              cnt_q <= cnt_q + 3'h1;
              tx_q  <= {tx_q[6:0], 1'b0};
              if (cnt_q == 3'h7) begin
                sda_oe_o <= 1'b0;
                state_q  <= S_RACK;
              end else begin
                sda_oe_o <= ~tx_q[6];
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              nack_q <= sda_f;
            end
            if (scl_fall) begin
              cnt_q <= 3'h0;
              if (nack_q) begin
                state_q <= S_IDLE;
              end else begin
                tx_q     <= rd_data;
                sda_oe_o <= ~rd_data[7];
                state_q  <= S_RD;
              end
            end
          end
          default: begin
            state_q  <= S_IDLE;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // tms_serial_slave

/* tms_map.vh */
// register offsets, field layout, reset values and timing counts of the temperature monitor serial slave
`ifndef TMS_MAP_VH
`define TMS_MAP_VH

// ************************************************************
// register pointers
// ************************************************************
`define TMS_PTR_HYST       8'h21
`define TMS_PTR_CFAULT     8'h22
`define TMS_PTR_PART       8'hFD
`define TMS_PTR_MAKER      8'hFE
`define TMS_PTR_SWRST      8'hFC

// ************************************************************
// reset values and field positions
// ************************************************************
`define TMS_HYST_RST       8'h0A
`define TMS_CFAULT_RST     8'h70
`define TMS_CFAULT_MASK    8'h7E
`define TMS_LIM_CNT_MSB    6
`define TMS_LIM_CNT_LSB    4
`define TMS_ALT_CNT_MSB    3
`define TMS_ALT_CNT_LSB    1

// ************************************************************
// bus codes
// ************************************************************
`define TMS_GC_ADDR        8'h00
`define TMS_GC_RESET       8'h06
`define TMS_HS_CODE        5'h01

// ************************************************************
// timing
// ************************************************************
`define TMS_CLK_KHZ        23'h1E848
`define TMS_TIMEOUT_MS     23'h20
`define TMS_TIMEOUT_CYC    (`TMS_TIMEOUT_MS * `TMS_CLK_KHZ)
`define TMS_SPIKE_FAST_NS  50
`define TMS_SPIKE_HS_NS    10
`define TMS_SPIKE_FAST_CYC ((`TMS_SPIKE_FAST_NS * `TMS_CLK_KHZ) / 1000000)
`define TMS_SPIKE_HS_CYC   ((`TMS_SPIKE_HS_NS * `TMS_CLK_KHZ) / 1000000 + 1)
`define TMS_STRAP_SETTLE   8'h10

`endif

/* tms_spike_filter.v */
// two-flop synchroniser followed by a programmable spike filter for one bus line
`timescale 1ns/1ps
module tms_spike_filter (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       line_i,
  input  wire [3:0] len_i,
  output reg        line_o
);

  reg       sync1_q;
  reg       sync2_q;
  reg [3:0] cnt_q;

  // ************************************************************
  // synchroniser and filter
  // ************************************************************
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      cnt_q   <= 4'h0;
      line_o  <= 1'b1;
    end else begin
      sync1_q <= line_i;
      sync2_q <= sync1_q;
      if (sync2_q == line_o) begin
        cnt_q <= 4'h0;
      end else if (cnt_q + 4'h1 >= len_i) begin
        cnt_q  <= 4'h0;
        line_o <= sync2_q;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

endmodule // tms_spike_filter

/* tms_strap_sense.v */
// samples one three-state address pin as low, high or floating after reset
`timescale 1ns/1ps
`include "tms_map.vh"
module tms_strap_sense (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       pin_i,
  output reg        pull_up_o,
  output reg        pull_dn_o,
  output reg  [1:0] level_o,
  output reg        done_o
);

  reg       sync1_q;
  reg       sync2_q;
  reg [7:0] wait_q;
  reg       up_val_q;

  // ************************************************************
  // pull up, sample, pull down, sample, then hold
  // ************************************************************
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_q   <= 1'b0;
      sync2_q   <= 1'b0;
      wait_q    <= 8'h00;
      up_val_q  <= 1'b0;
      pull_up_o <= 1'b1;
      pull_dn_o <= 1'b0;
      level_o   <= 2'h0;
      done_o    <= 1'b0;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      if (!done_o) begin
        if (wait_q != `TMS_STRAP_SETTLE) begin
          wait_q <= wait_q + 8'h01;
        end else if (pull_up_o) begin
          up_val_q  <= sync2_q;
          pull_up_o <= 1'b0;
          pull_dn_o <= 1'b1;
          wait_q    <= 8'h00;
        end else begin
          pull_dn_o <= 1'b0;
          done_o    <= 1'b1;
          level_o   <= (up_val_q != sync2_q) ? 2'h2 : {1'b0, sync2_q};
        end
      end
    end
  end

endmodule // tms_strap_sense

/* tms_serial_slave_props.sv */
// assertions on the ports of the temperature monitor serial slave
`timescale 1ns/1ps
module tms_serial_slave_props #(
  parameter [22:0] TIMEOUT_CYC = 23'd2000
) (
  input wire       clk_i,
  input wire       rst_n_i,
  input wire       scl_i,
  input wire       sda_i,
  input wire       sda_o,
  input wire       sda_oe_o,
  input wire       address_select_low_pull_up_o,
  input wire       address_select_low_pull_dn_o,
  input wire       address_select_high_pull_up_o,
  input wire       address_select_high_pull_dn_o,
  input wire       alert_pin_function_select_i,
  input wire [7:0] limit_pin_hyst_o,
  input wire [7:0] shared_alert_pin_hyst_o,
  input wire [2:0] limit_pin_need_o,
  input wire [2:0] shared_alert_pin_need_o,
  input wire [6:0] slave_addr_o,
  input wire       addr_valid_o,
  input wire       hs_mode_o
);
  // ************************************************************
  // helpers
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [23:0] hold_q;
  always_ff @(posedge clk_i) hold_q <= (!rst_n_i || !sda_oe_o) ? 24'h0 : hold_q + 24'h1;
  sequence stop_seq;
    scl_i && $rose(sda_i);
  endsequence
  sequence sel_on;
    $past(rst_n_i) && $past(alert_pin_function_select_i);
  endsequence
  sequence sel_off;
    $past(rst_n_i) && !$past(alert_pin_function_select_i);
  endsequence
  // ************************************************************
  // properties
  // ************************************************************
  sda_low_only_a: assert property (sda_o == 1'b0)
    else $error("sda driven high");
  alert_hyst_on_a: assert property (sel_on |-> shared_alert_pin_hyst_o == limit_pin_hyst_o)
    else $error("alert hysteresis not applied");
  alert_hyst_off_a: assert property (sel_off |-> shared_alert_pin_hyst_o == 8'h00)
    else $error("alert hysteresis not cleared");
  need_range_a: assert property (limit_pin_need_o inside {[3'h1:3'h4]} && shared_alert_pin_need_o inside {[3'h1:3'h4]})
    else $error("need count out of range");
  addr_ready_a: assert property ($rose(rst_n_i) |-> ##[1:80] addr_valid_o)
    else $error("address not resolved");
  addr_hold_a: assert property (addr_valid_o && $past(addr_valid_o, 2) |-> $stable(slave_addr_o) && addr_valid_o)
    else $error("address changed");
  addr_legal_a: assert property (addr_valid_o && $past(addr_valid_o) |-> slave_addr_o inside {[7'h48:7'h4F], 7'h37})
    else $error("illegal address");
  pull_excl_a: assert property (!(address_select_low_pull_up_o && address_select_low_pull_dn_o) &&
    !(address_select_high_pull_up_o && address_select_high_pull_dn_o))
    else $error("both pulls on");
  oe_scl_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("sda moved with scl high");
  stop_idle_a: assert property (stop_seq |-> ##[1:16] (!hs_mode_o && !sda_oe_o))
    else $error("not idle after stop");
  bus_release_a: assert property (hold_q < TIMEOUT_CYC + 23'd64)
    else $error("bus held past timeout");
endmodule // tms_serial_slave_props

bind tms_serial_slave tms_serial_slave_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) props (
  .clk_i, .rst_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
  .address_select_low_pull_up_o, .address_select_low_pull_dn_o,
  .address_select_high_pull_up_o, .address_select_high_pull_dn_o,
  .alert_pin_function_select_i, .limit_pin_hyst_o, .shared_alert_pin_hyst_o,
  .limit_pin_need_o, .shared_alert_pin_need_o, .slave_addr_o, .addr_valid_o, .hs_mode_o
);

/* tms_bus_master.sv */
// two-wire bus master model facing the slave
`timescale 1ns/1ps
module tms_bus_master #(
  parameter int Q = 12
) (
  input  wire  clk_i,
  input  wire  sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic pause(input int n);
    repeat (n * Q) @(negedge clk_i);
  endtask
  // start or repeated start: sda falls with scl high
  task automatic start;
    pause(1);
    sda_oe_o = 1'b0;
    pause(1);
    scl_o = 1'b1;
    pause(2);
    sda_oe_o = 1'b1;
    pause(2);
    scl_o = 1'b0;
  endtask
  task automatic stop;
    pause(1);
    sda_oe_o = 1'b1;
    pause(1);
    scl_o = 1'b1;
    pause(2);
    sda_oe_o = 1'b0;
    pause(2);
  endtask
  // data only moves while scl is low
  task automatic bit_x(input logic b, output logic r);
    pause(1);
    sda_oe_o = ~b;
    pause(1);
    scl_o = 1'b1;
    pause(2);
    r = sda_i;
    scl_o = 1'b0;
  endtask
  // eight bits msb first, then the acknowledge clock
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(nack, r);
  endtask
endmodule // tms_bus_master

/* tms_serial_slave_tb.sv */
// self-checking testbench of the temperature monitor serial slave
`timescale 1ns/1ps
module tms_serial_slave_tb;
  // ************************************************************
  // signals
  // ************************************************************
  localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
  localparam logic [7:0] PART  = 8'hC3; // arbitrary value
  logic       clk_i, rst_n_i, sel_i, scl, m_oe, s_oe, s_do, av, hs;
  logic       lo_pu, lo_pd, hi_pu, hi_pd;
  logic [1:0] lo_st, hi_st;
  logic [7:0] hyst, ahyst;
  logic [2:0] lneed, aneed;
  logic [6:0] addr;
  int         err_total, checks;
  logic [6:0] adr_tab [0:8] = '{7'h4C, 7'h4D, 7'h48, 7'h4E, 7'h4F, 7'h4A, 7'h49, 7'h4B, 7'h37};
  wire        sda  = !(m_oe || (s_oe && !s_do));
  wire        a_lo = (lo_st == 2'h2) ? lo_pu : lo_st[0];
  wire        a_hi = (hi_st == 2'h2) ? hi_pu : hi_st[0];
  tms_serial_slave #(.TIMEOUT_CYC(23'd2000), .MAKER_ID(MAKER), .PART_ID(PART)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(s_do), .sda_oe_o(s_oe),
    .address_select_high_i(a_hi), .address_select_high_pull_up_o(hi_pu),
    .address_select_high_pull_dn_o(hi_pd), .address_select_low_i(a_lo),
    .address_select_low_pull_up_o(lo_pu), .address_select_low_pull_dn_o(lo_pd),
    .alert_pin_function_select_i(sel_i), .limit_pin_hyst_o(hyst), .shared_alert_pin_hyst_o(ahyst),
    .limit_pin_need_o(lneed), .shared_alert_pin_need_o(aneed), .slave_addr_o(addr),
    .addr_valid_o(av), .hs_mode_o(hs)
  );
  tms_bus_master bus (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic do_reset;
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    for (int n = 0; n < 200 && av !== 1'b1; n++) @(negedge clk_i);
    chk({7'h0, av}, 8'h01, "strap sense");
  endtask
  task automatic reg_wr(input logic [7:0] p, input logic [7:0] d);
    logic a;
    bus.start();
    bus.wr_byte(8'h98, a);
    bus.wr_byte(p, a);
    bus.wr_byte(d, a);
    bus.stop();
    chk({7'h0, a}, 8'h01, "write ack");
  endtask
  task automatic rd_cur(output logic [7:0] d);
    logic a;
    bus.start();
    bus.wr_byte(8'h99, a);
    bus.rd_byte(1'b1, d);
    bus.stop();
  endtask
  task automatic reg_rd(input logic [7:0] p, output logic [7:0] d);
    logic a;
    bus.start();
    bus.wr_byte(8'h98, a);
    bus.wr_byte(p, a);
    rd_cur(d);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_defaults;
    logic [7:0] d;
    reg_rd(8'h21, d);
    chk(d, 8'h0A, "hyst reset");
    reg_rd(8'h22, d);
    chk(d, 8'h70, "fault reset");
  endtask
  task automatic t_ident;
    logic [7:0] d;
    reg_wr(8'hFD, 8'h00);
    reg_wr(8'hFE, 8'hFF);
    reg_rd(8'hFD, d);
    chk(d, PART, "part id");
    reg_rd(8'hFE, d);
    chk(d, MAKER, "maker id");
  endtask
  task automatic t_hyst;
    logic [7:0] d;
    reg_wr(8'h21, 8'hFF);
    reg_rd(8'h21, d);
    chk(d, 8'hFF, "hyst max");
    rd_cur(d);
    chk(d, 8'hFF, "pointer kept");
    chk(hyst, 8'hFF, "limit hyst");
    sel_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk(ahyst, 8'hFF, "alert hyst on");
    sel_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk(ahyst, 8'h00, "alert hyst off");
  endtask
  task automatic t_fault;
    logic [7:0] d;
    logic [2:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 3'((1 << i) - 1);
      reg_wr(8'h22, {1'b1, c, c, 1'b1});
      chk({5'h0, lneed}, 8'(i + 1), "limit need");
      chk({5'h0, aneed}, 8'(i + 1), "alert need");
      reg_rd(8'h22, d);
      chk(d, {1'b0, c, c, 1'b0}, "fault field");
    end
  endtask
  task automatic t_hs;
    logic [7:0] d;
    logic a;
    bus.start();
    bus.wr_byte(8'h08, a);
    chk({7'h0, a}, 8'h00, "master code nack");
    chk({7'h0, hs}, 8'h01, "hs filters on");
    reg_wr(8'hFC, 8'h00);
    chk({7'h0, hs}, 8'h00, "hs after stop");
    chk(hyst, 8'h0A, "limit hyst reset");
    reg_rd(8'h22, d);
    chk(d, 8'h70, "soft reset");
  endtask
  task automatic t_wrong_addr;
    logic a;
    bus.start();
    bus.wr_byte(8'hA0, a);
    bus.stop();
    chk({7'h0, a}, 8'h00, "foreign address");
  endtask
  task automatic t_gcall;
    logic [7:0] d;
    logic a;
    reg_wr(8'h21, 8'h33);
    bus.start();
    bus.wr_byte(8'h00, a);
    chk({7'h0, a}, 8'h01, "general call");
    bus.wr_byte(8'h07, a);
    bus.stop();
    chk({7'h0, a}, 8'h00, "other second byte");
    reg_rd(8'h21, d);
    chk(d, 8'h33, "kept");
    bus.start();
    bus.wr_byte(8'h00, a);
    bus.wr_byte(8'h06, a);
    bus.stop();
    reg_rd(8'h21, d);
    chk(d, 8'h0A, "general reset");
  endtask
  task automatic t_timeout;
    logic a;
    bus.start();
    bus.wr_byte(8'h98, a);
    repeat (2100) @(negedge clk_i);
    bus.wr_byte(8'h21, a);
    bus.stop();
    chk({7'h0, a}, 8'h00, "idle after stall");
  endtask
  task automatic t_straps;
    for (int i = 0; i < 9; i++) begin
      lo_st = 2'(i / 3);
      hi_st = 2'(i % 3);
      do_reset();
      chk({1'b0, addr}, {1'b0, adr_tab[i]}, "strap address");
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ************************************************************
  // sequence and watchdog
  // ************************************************************
  initial begin
    rst_n_i = 1'b0;
    sel_i = 1'b0;
    lo_st = 2'h0;
    hi_st = 2'h0;
    err_total = 0;
    checks = 0;
    do_reset();
    t_defaults();
    t_ident();
    t_hyst();
    t_fault();
    t_hs();
    t_wrong_addr();
    t_gcall();
    t_timeout();
    t_straps();
    wrap_up();
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    err_total++;
    $display("unexpected at %0t: run did not finish", $time);
    wrap_up();
  end
endmodule // tms_serial_slave_tb
